/* File: common/pump_ctrl_regs.svh */
// Register offsets, field positions, reset values and timing counts
// of the two-pump delay and alarm controller.
// Assumes a 32-bit AXI4-Lite register bus and a 250 MHz system clock.
`ifndef PUMP_CTRL_REGS_SVH
`define PUMP_CTRL_REGS_SVH

`define OFS_DELAYS     8'h00
`define OFS_VOLT       8'h04
`define OFS_MODE       8'h08
`define OFS_TIMES      8'h0c
`define OFS_STATUS     8'h10
`define OFS_TEST_LEFT  8'h14

`define POS_START      0
`define POS_STOP       8
`define POS_VDLY       16
`define POS_FDLY       24
`define POS_VMAX       0
`define POS_VMIN       16
`define POS_VEN        0
`define POS_F60        1
`define POS_CLEAN      2
`define POS_MANMODE    3
`define POS_RLY_V      4
`define POS_RLY_F      5
`define POS_MAXP       8
`define POS_ROT        12
`define POS_FDEV       16
`define POS_TDUR       24
`define POS_THOURS     0
`define POS_MANTIME    16

`define START_DLY_RST  7'h04
`define START_MIN      7'h04
`define SEC_MAX        7'h63
`define STOP_DLY_RST   7'h01
`define VOLT_DLY_RST   7'h05
`define FREQ_DLY_RST   7'h02
`define VMAX_RST       9'h1b8
`define VMIN_RST       9'h168
`define FDEV_RST       3'h2
`define NOM_50         7'h32
`define NOM_60         7'h3c
`define MAXP_RST       2'h2
`define TDUR_RST       7'h05
`define MANTIME_RST    10'h005
`define TEST_CAP_S     7'h03

`define CLK_PERIOD_NS  4
`define TICK_PERIOD_NS 1000000000
`define HOUR_S         3600

`endif

/* File: common/pump_ctrl_pkg.sv */
// Types of the two-pump delay and alarm controller.
// Assumes pump_ctrl_regs.svh supplies offsets and defaults.
package pump_ctrl_pkg;

   typedef enum logic [1:0] {TEST_IDLE = 2'b00, TEST_P1 = 2'b01, TEST_P2 = 2'b10} test_st_t;

   typedef struct packed {
      logic [6:0] start_dly;
      logic [6:0] stop_dly;
      logic [6:0] volt_dly;
      logic [6:0] freq_dly;
      logic [8:0] vmax;
      logic [8:0] vmin;
      logic       volt_en;
      logic       freq_60;
      logic       clean_prog;
      logic       manual_mode;
      logic       relay_volt;
      logic       relay_freq;
      logic [1:0] max_pumps;
      logic [2:0] rotation;
      logic [2:0] freq_dev;
      logic [6:0] test_dur;
      logic [9:0] test_hours;
      logic [9:0] man_time;
   } cfg_t;

   typedef struct packed {
      cfg_t            cfg;
      logic [27:0]     tick_cnt;
      logic            tick;
      logic [5:0]      sync1;
      logic [5:0]      sync2;
      logic [1:0]      run;
      logic [1:0][6:0] dly_cnt;
      logic [1:0]      man_on;
      logic [1:0][9:0] man_cnt;
      logic [6:0]      vcnt;
      logic [6:0]      fcnt;
      logic            valarm;
      logic            falarm;
      logic            relay;
      test_st_t        tst;
      logic            busy;
      logic [6:0]      tcnt;
      logic [9:0]      hr_left;
      logic [11:0]     sec_in_hr;
      logic [1:0]      pump;
      logic            aw_got;
      logic            w_got;
      logic [7:0]      awaddr;
      logic [31:0]     wdata;
      logic [3:0]      wstrb;
      logic            awready;
      logic            wready;
      logic            bvalid;
      logic [1:0]      bresp;
      logic            arready;
      logic            rvalid;
      logic [31:0]     rdata;
      logic [1:0]      rresp;
   } st_t;

endpackage

/* File: logic/pump_ctrl.sv */
// Two-pump delayed start/stop control, mains voltage and frequency
// alarms, periodic self-test, manual run and simultaneity limit.
// Assumes switches and buttons are asynchronous pins, measured volts
// and hertz come from logic on mclk_in, and an AXI4-Lite master.
`timescale 1ns/1ps
`default_nettype none
`include "pump_ctrl_regs.svh"

// Function
// [R01] Pump starts only after its start condition held for the start delay, 4..99 s.
// [R02] Running pump keeps running for the common stop delay after stop condition.
// [R03] Clean program: minimum level during stop delay stops all pumps immediately.
// [R04] Voltage alarm enable bit: 0 disables, 1 enables, default 1.
// [R05] Voltage alarm stops all pumps, flags alarm, optionally drives relay.
// [R06] Voltage above over-voltage threshold is a fault.
// [R07] Voltage below under-voltage threshold is a fault.
// [R08] Voltage alarm only after fault persists for its delay without break.
// [R09] Nominal mains frequency selectable 50 or 60 Hz, default 50.
// [R10] Frequency outside nominal plus or minus deviation is a fault.
// [R11] Frequency alarm is always enabled.
// [R12] Frequency alarm only after fault persists for its delay.
// [R13] Self-test every programmed hours from activation; zero disables.
// [R14] Remaining self-test hours readable and restorable after power loss.
// [R15] Self-test runs pump one for duration, then pump two.
// [R16] Test duration 0..99 s, capped at 3 s while minimum level active.
// [R17] Hold-to-run manual mode runs while button held, bypassing protections.
// [R18] Timed manual mode keeps running manual time after release, with protections.
// [R19] Manual time 0..999 s; zero runs until the stop button.
// [R20] Never more pumps running than simultaneity limit 1 or 2.
// [R21] Rotation zero: each pump follows only its own conditions.
// [R22] Delays count one-second ticks; persistence timers restart when condition clears.
module pump_ctrl #(
   parameter int TICK_CYCLES = `TICK_PERIOD_NS / `CLK_PERIOD_NS,
   parameter int HOUR_TICKS  = `HOUR_S
) (
   input  wire logic        mclk_in,               // System clock
   input  wire logic        rst_in,                // Async reset, high
   input  wire logic [1:0]  demand_in,             // Start condition per pump
   input  wire logic        min_level_in,          // Minimum level active
   input  wire logic [1:0]  manual_run_button_in,  // Manual run per pump
   input  wire logic        stop_button_in,        // Manual stop
   input  wire logic [8:0]  volt_meas_in,          // Mains volts
   input  wire logic [6:0]  freq_meas_in,          // Mains hertz
   output logic      [1:0]  pump_run_out,          // Pump run commands
   output logic             alarm_relay_out,       // Alarm relay
   output logic             volt_alarm_out,        // Voltage alarm
   output logic             freq_alarm_out,        // Frequency alarm
   output logic             test_busy_out,         // Self-test running
   input  wire logic [7:0]  s_axi_awaddr_in,       // Write address
   input  wire logic        s_axi_awvalid_in,      // Write address valid
   output logic             s_axi_awready_out,     // Write address ready
   input  wire logic [31:0] s_axi_wdata_in,        // Write data
   input  wire logic [3:0]  s_axi_wstrb_in,        // Byte strobes
   input  wire logic        s_axi_wvalid_in,       // Write data valid
   output logic             s_axi_wready_out,      // Write data ready
   output logic      [1:0]  s_axi_bresp_out,       // Write response
   output logic             s_axi_bvalid_out,      // Write response valid
   input  wire logic        s_axi_bready_in,       // Write response ready
   input  wire logic [7:0]  s_axi_araddr_in,       // Read address
   input  wire logic        s_axi_arvalid_in,      // Read address valid
   output logic             s_axi_arready_out,     // Read address ready
   output logic      [31:0] s_axi_rdata_out,       // Read data
   output logic      [1:0]  s_axi_rresp_out,       // Read response
   output logic             s_axi_rvalid_out,      // Read data valid
   input  wire logic        s_axi_rready_in        // Read data ready
);

////////////////////////////////////////////////////////////////////////////////
// Reset values

   localparam pump_ctrl_pkg::cfg_t CFG_RST = '{
      start_dly: `START_DLY_RST, stop_dly: `STOP_DLY_RST, volt_dly: `VOLT_DLY_RST,
      freq_dly: `FREQ_DLY_RST, vmax: `VMAX_RST, vmin: `VMIN_RST, volt_en: 1'b1,
      freq_60: 1'b0, clean_prog: 1'b0, manual_mode: 1'b0, relay_volt: 1'b1,
      relay_freq: 1'b1, max_pumps: `MAXP_RST, rotation: 3'h0, freq_dev: `FDEV_RST,
      test_dur: `TDUR_RST, test_hours: 10'h000, man_time: `MANTIME_RST};
   localparam pump_ctrl_pkg::st_t ST_RST = '{cfg: CFG_RST, tst: pump_ctrl_pkg::TEST_IDLE, default: '0};

   pump_ctrl_pkg::st_t st;
   pump_ctrl_pkg::st_t nxt;

   logic [1:0] dem;
   logic       minl;
   logic [1:0] btn;
   logic       stopb;
   logic       hold_to_run_setting;
   logic       prot;
   logic       stop_counting;

   assign dem                 = st.sync2[1:0];
   assign minl                = st.sync2[2];
   assign btn                 = st.sync2[4:3];
   assign stopb               = st.sync2[5];
   assign hold_to_run_setting = ~st.cfg.manual_mode;
   assign prot                = st.valarm | st.falarm;
   assign stop_counting       = |(st.run & ~dem);

////////////////////////////////////////////////////////////////////////////////
// Register decode

   function automatic logic ofs_ok(input logic [7:0] a);
      ofs_ok = (a == `OFS_DELAYS) || (a == `OFS_VOLT) || (a == `OFS_MODE) ||
               (a == `OFS_TIMES) || (a == `OFS_STATUS) || (a == `OFS_TEST_LEFT);
   endfunction

   function automatic logic [31:0] rd_word(input logic [7:0] a, input pump_ctrl_pkg::st_t s);
      logic [31:0] w;
      w = 32'h0000_0000;
      case (a)
         `OFS_DELAYS:
         begin
            w[`POS_START +: 7] = s.cfg.start_dly;
            w[`POS_STOP +: 7]  = s.cfg.stop_dly;
            w[`POS_VDLY +: 7]  = s.cfg.volt_dly;
            w[`POS_FDLY +: 7]  = s.cfg.freq_dly;
         end
         `OFS_VOLT:
         begin
            w[`POS_VMAX +: 9] = s.cfg.vmax;
            w[`POS_VMIN +: 9] = s.cfg.vmin;
         end
         `OFS_MODE:
         begin
            w[`POS_VEN]       = s.cfg.volt_en;
            w[`POS_F60]       = s.cfg.freq_60;
            w[`POS_CLEAN]     = s.cfg.clean_prog;
            w[`POS_MANMODE]   = s.cfg.manual_mode;
            w[`POS_RLY_V]     = s.cfg.relay_volt;
            w[`POS_RLY_F]     = s.cfg.relay_freq;
            w[`POS_MAXP +: 2] = s.cfg.max_pumps;
            w[`POS_ROT +: 3]  = s.cfg.rotation;
            w[`POS_FDEV +: 3] = s.cfg.freq_dev;
            w[`POS_TDUR +: 7] = s.cfg.test_dur;
         end
         `OFS_TIMES:
         begin
            w[`POS_THOURS +: 10]  = s.cfg.test_hours;
            w[`POS_MANTIME +: 10] = s.cfg.man_time;
         end
         `OFS_STATUS:
         begin
            w[1:0] = s.pump;
            w[4]   = s.valarm;
            w[5]   = s.falarm;
            w[6]   = s.relay;
            w[9:8] = s.tst;
         end
         `OFS_TEST_LEFT:
            w[9:0] = s.hr_left;
         default:
            w = 32'h0000_0000;
      endcase
      rd_word = w;
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n, input logic [3:0] b);
      logic [31:0] r;
      r = o;
      for (int k = 0; k < 4; k++)
      begin
         if (b[k])
            r[8*k +: 8] = n[8*k +: 8];
      end
      merge = r;
   endfunction

////////////////////////////////////////////////////////////////////////////////
// Next state

   always_comb
   begin
      logic        vbad;
      logic        fbad;
      logic [6:0]  nom;
      logic [6:0]  dur;
      logic [1:0]  man_run;
      logic [1:0]  test_run;
      logic [1:0]  want;
      logic [31:0] w;
      vbad     = 1'b0;
      fbad     = 1'b0;
      nom      = `NOM_50;
      dur      = 7'h00;
      man_run  = 2'b00;
      test_run = 2'b00;
      want     = 2'b00;
      w        = 32'h0000_0000;
      nxt      = st;
      // Pins pass two flops before use
      nxt.sync1 = {stop_button_in, manual_run_button_in, min_level_in, demand_in};
      nxt.sync2 = st.sync1;
      // [R22] one-second tick
      if (st.tick_cnt == 28'(TICK_CYCLES - 1))
      begin
         nxt.tick_cnt = 28'h0000000;
         nxt.tick     = 1'b1;
      end
      else
      begin
         nxt.tick_cnt = st.tick_cnt + 28'h0000001;
         nxt.tick     = 1'b0;
      end
      // [R04] [R06] [R07] voltage fault
      vbad = st.cfg.volt_en && ((volt_meas_in > st.cfg.vmax) || (volt_meas_in < st.cfg.vmin));
      // [R08] [R22] persistence, restart on clear
      if (!vbad)
         nxt.vcnt = 7'h00;
      else if (st.tick && st.vcnt != 7'h7f)
         nxt.vcnt = st.vcnt + 7'h01;
      nxt.valarm = vbad && (nxt.vcnt >= st.cfg.volt_dly);
      // [R09] [R10] [R11] frequency band, no enable
      nom  = st.cfg.freq_60 ? `NOM_60 : `NOM_50;
      fbad = (freq_meas_in > nom + {4'h0, st.cfg.freq_dev}) || (freq_meas_in < nom - {4'h0, st.cfg.freq_dev});
      // [R12] frequency persistence
      if (!fbad)
         nxt.fcnt = 7'h00;
      else if (st.tick && st.fcnt != 7'h7f)
         nxt.fcnt = st.fcnt + 7'h01;
      nxt.falarm = fbad && (nxt.fcnt >= st.cfg.freq_dly);
      // [R05] relay follows its configuration
      nxt.relay = (st.valarm && st.cfg.relay_volt) || (st.falarm && st.cfg.relay_freq);
      // [R21] each pump runs on its own conditions
      for (int i = 0; i < 2; i++)
      begin
         if (!st.run[i])
         begin
            // [R01] start delay
            if (!dem[i])
               nxt.dly_cnt[i] = 7'h00;
            else if (st.dly_cnt[i] >= st.cfg.start_dly)
            begin
               nxt.run[i]     = 1'b1;
               nxt.dly_cnt[i] = 7'h00;
            end
            else if (st.tick)
               nxt.dly_cnt[i] = st.dly_cnt[i] + 7'h01;
         end
         else
         begin
            // [R02] stop delay
            if (dem[i])
               nxt.dly_cnt[i] = 7'h00;
            else if (st.dly_cnt[i] >= st.cfg.stop_dly)
            begin
               nxt.run[i]     = 1'b0;
               nxt.dly_cnt[i] = 7'h00;
            end
            else if (st.tick)
               nxt.dly_cnt[i] = st.dly_cnt[i] + 7'h01;
         end
      end
      // [R03] dry stop during stop delay
      // [R05] alarms drop automatic runs
      if ((st.cfg.clean_prog && minl && stop_counting) || prot)
      begin
         nxt.run     = 2'b00;
         nxt.dly_cnt = '0;
      end
      // Manual run per pump
      for (int i = 0; i < 2; i++)
      begin
         if (hold_to_run_setting || stopb || prot)
         begin
            nxt.man_on[i]  = 1'b0;
            nxt.man_cnt[i] = 10'h000;
         end
         else if (btn[i])
         begin
            nxt.man_on[i]  = 1'b1;
            nxt.man_cnt[i] = 10'h000;
         end
         // [R19] zero means no time limit
         else if (st.man_on[i] && st.cfg.man_time != 10'h000)
         begin
            if (st.man_cnt[i] >= st.cfg.man_time)
               nxt.man_on[i] = 1'b0;
            else if (st.tick)
               nxt.man_cnt[i] = st.man_cnt[i] + 10'h001;
         end
      end
      // [R17] hold-to-run ignores protections
      // [R18] timed run gated by protections
      man_run = hold_to_run_setting ? btn : (st.man_on & ~{2{prot}});
      // [R13] [R14] hour countdown from activation
      if (st.cfg.test_hours != 10'h000 && st.tick)
      begin
         if (st.sec_in_hr >= 12'(HOUR_TICKS - 1))
         begin
            nxt.sec_in_hr = 12'h000;
            if (st.hr_left <= 10'h001)
            begin
               nxt.hr_left = st.cfg.test_hours;
               if (st.tst == pump_ctrl_pkg::TEST_IDLE)
               begin
                  nxt.tst  = pump_ctrl_pkg::TEST_P1;
                  nxt.tcnt = 7'h00;
               end
            end
            else
               nxt.hr_left = st.hr_left - 10'h001;
         end
         else
            nxt.sec_in_hr = st.sec_in_hr + 12'h001;
      end
      // [R16] duration capped on low level
      dur = (minl && st.cfg.test_dur > `TEST_CAP_S) ? `TEST_CAP_S : st.cfg.test_dur;
      // [R15] pump one then pump two
      case (st.tst)
         pump_ctrl_pkg::TEST_P1:
         begin
            test_run = 2'b01;
            if (st.tcnt >= dur)
            begin
               nxt.tst  = pump_ctrl_pkg::TEST_P2;
               nxt.tcnt = 7'h00;
            end
            else if (st.tick)
               nxt.tcnt = st.tcnt + 7'h01;
         end
         pump_ctrl_pkg::TEST_P2:
         begin
            test_run = 2'b10;
            if (st.tcnt >= dur)
            begin
               nxt.tst  = pump_ctrl_pkg::TEST_IDLE;
               nxt.tcnt = 7'h00;
            end
            else if (st.tick)
               nxt.tcnt = st.tcnt + 7'h01;
         end
         default:
            test_run = 2'b00;
      endcase
      nxt.busy = (nxt.tst != pump_ctrl_pkg::TEST_IDLE);
      // [R05] alarm drops automatic and test runs, at the pump output one cycle after the alarm flag
      want = man_run | ((st.run | test_run) & ~{2{prot}});
      // [R20] simultaneity limit keeps the pump already running
      if (st.cfg.max_pumps == 2'h1 && want == 2'b11)
         nxt.pump = (st.pump == 2'b10) ? 2'b10 : 2'b01;
      else
         nxt.pump = want;
      // Register bus: write channel
      if (st.bvalid && s_axi_bready_in)
         nxt.bvalid = 1'b0;
      if (s_axi_awvalid_in && st.awready)
      begin
         nxt.aw_got = 1'b1;
         nxt.awaddr = s_axi_awaddr_in;
      end
      if (s_axi_wvalid_in && st.wready)
      begin
         nxt.w_got = 1'b1;
         nxt.wdata = s_axi_wdata_in;
         nxt.wstrb = s_axi_wstrb_in;
      end
      if (st.aw_got && st.w_got && !st.bvalid)
      begin
         nxt.aw_got = 1'b0;
         nxt.w_got  = 1'b0;
         nxt.bvalid = 1'b1;
         nxt.bresp  = ofs_ok(st.awaddr) ? 2'b00 : 2'b10;
         w = merge(rd_word(st.awaddr, st), st.wdata, st.wstrb);
         case (st.awaddr)
            `OFS_DELAYS:
            begin
               // [R01] start delay held inside its range
               nxt.cfg.start_dly = (w[`POS_START +: 7] < `START_MIN) ? `START_MIN :
                                   (w[`POS_START +: 7] > `SEC_MAX) ? `SEC_MAX : w[`POS_START +: 7];
               nxt.cfg.stop_dly  = w[`POS_STOP +: 7];
               nxt.cfg.volt_dly  = w[`POS_VDLY +: 7];
               nxt.cfg.freq_dly  = w[`POS_FDLY +: 7];
            end
            `OFS_VOLT:
            begin
               nxt.cfg.vmax = w[`POS_VMAX +: 9];
               nxt.cfg.vmin = w[`POS_VMIN +: 9];
            end
            `OFS_MODE:
            begin
               nxt.cfg.volt_en     = w[`POS_VEN];
               nxt.cfg.freq_60     = w[`POS_F60];
               nxt.cfg.clean_prog  = w[`POS_CLEAN];
               nxt.cfg.manual_mode = w[`POS_MANMODE];
               nxt.cfg.relay_volt  = w[`POS_RLY_V];
               nxt.cfg.relay_freq  = w[`POS_RLY_F];
               // [R20] limit is one or two
               nxt.cfg.max_pumps   = (w[`POS_MAXP +: 2] == 2'h1) ? 2'h1 : 2'h2;
               nxt.cfg.rotation    = w[`POS_ROT +: 3];
               nxt.cfg.freq_dev    = w[`POS_FDEV +: 3];
               nxt.cfg.test_dur    = w[`POS_TDUR +: 7];
            end
            `OFS_TIMES:
            begin
               // [R13] new interval restarts the count
               nxt.cfg.test_hours = w[`POS_THOURS +: 10];
               nxt.cfg.man_time   = w[`POS_MANTIME +: 10];
               nxt.hr_left        = w[`POS_THOURS +: 10];
               nxt.sec_in_hr      = 12'h000;
            end
            // [R14] restore of saved remaining hours
            `OFS_TEST_LEFT:
               nxt.hr_left = w[9:0];
            default:
               nxt.bresp = ofs_ok(st.awaddr) ? 2'b00 : 2'b10;
         endcase
      end
      nxt.awready = !nxt.aw_got && !nxt.bvalid;
      nxt.wready  = !nxt.w_got && !nxt.bvalid;
      // Register bus: read channel
      if (st.rvalid && s_axi_rready_in)
         nxt.rvalid = 1'b0;
      if (s_axi_arvalid_in && st.arready)
      begin
         nxt.rvalid = 1'b1;
         nxt.rdata  = rd_word(s_axi_araddr_in, st);
         nxt.rresp  = ofs_ok(s_axi_araddr_in) ? 2'b00 : 2'b10;
      end
      nxt.arready = !nxt.rvalid;
   end

   always_ff @(posedge mclk_in or posedge rst_in)
   begin
      if (rst_in)
         st <= ST_RST;
      else
         st <= nxt;
   end

////////////////////////////////////////////////////////////////////////////////
// Outputs

   assign pump_run_out      = st.pump;
   assign alarm_relay_out   = st.relay;
   assign volt_alarm_out    = st.valarm;
   assign freq_alarm_out    = st.falarm;
   assign test_busy_out     = st.busy;
   assign s_axi_awready_out = st.awready;
   assign s_axi_wready_out  = st.wready;
   assign s_axi_bresp_out   = st.bresp;
   assign s_axi_bvalid_out  = st.bvalid;
   assign s_axi_arready_out = st.arready;
   assign s_axi_rdata_out   = st.rdata;
   assign s_axi_rresp_out   = st.rresp;
   assign s_axi_rvalid_out  = st.rvalid;

////////////////////////////////////////////////////////////////////////////////
// Checks

   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (rst_in);

   a_limit_one_pump: assert property ((st.cfg.max_pumps == 2'h1 && $past(st.cfg.max_pumps) == 2'h1)
      |-> st.pump != 2'b11) else $error("two pumps under limit one"); // [R20]
   a_volt_stops_pumps: assert property ((st.valarm && !(hold_to_run_setting && |btn))
      |=> st.pump == 2'b00) else $error("pump runs under voltage alarm"); // [R05]
   a_volt_persist: assert property ($rose(st.valarm) |-> st.vcnt >= st.cfg.volt_dly)
      else $error("voltage alarm before delay"); // [R08]
   a_volt_disabled: assert property (!st.cfg.volt_en |=> !st.valarm)
      else $error("voltage alarm while disabled"); // [R04]
   a_freq_persist: assert property ($rose(st.falarm) |-> st.fcnt >= st.cfg.freq_dly)
      else $error("frequency alarm before delay"); // [R12]
   a_persist_restart: assert property ((volt_meas_in <= st.cfg.vmax && volt_meas_in >= st.cfg.vmin)
      |=> st.vcnt == 7'h00) else $error("voltage timer not restarted"); // [R22]
   a_clean_dry_stop: assert property ((st.cfg.clean_prog && minl && stop_counting)
      |=> st.run == 2'b00) else $error("dry stop missed"); // [R03]
   a_test_sequence: assert property ((st.tst == pump_ctrl_pkg::TEST_P1 ##1 st.tst != pump_ctrl_pkg::TEST_P1)
      |-> st.tst == pump_ctrl_pkg::TEST_P2) else $error("test skipped pump two"); // [R15]

   c_volt_alarm: cover property ($rose(st.valarm));
   c_test_p2: cover property (st.tst == pump_ctrl_pkg::TEST_P2);
   c_both_pumps: cover property (st.pump == 2'b11);

endmodule
`default_nettype wire

/* File: tb/pump_field.sv */
// Field model: demand contacts settle one edge after the wanted level.
// Assumes the bench changes the wanted level between edges.
`timescale 1ns/1ps
`default_nettype none
module pump_field (
   input  wire logic       mclk_in,    // Clock
   input  wire logic [1:0] want_in,    // Wanted level
   output logic      [1:0] demand_out  // Switch contacts
);
   always_ff @(posedge mclk_in)
      demand_out <= want_in;
endmodule
`default_nettype wire

/* File: tb/tb.sv */
// Bench: register defaults, pump delays, pump limit, mains alarms,
// manual run and self-test.
// Assumes a 10-cycle tick.
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic        mclk = 1'b0, rst = 1'b1, awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0, rre = 1'b0;
   logic [1:0]  want = 2'h0, manual_run_button = 2'h0, dem, run, br, rr, rsp;
   logic [8:0]  volt = 9'h190;
   logic [6:0]  freq = 7'h32;
   logic [7:0]  awa = 8'h00;
   logic [31:0] wd = 32'h0, rd, dat;
   logic        awr, wrd, bv, arr, rv, rly, va, fa, busy, min_pin = 1'b0;
   int          n_fail = 0;
   int          tests_run = 0;
   always #2 mclk = ~mclk;
   pump_ctrl #(.TICK_CYCLES(10), .HOUR_TICKS(4)) u_pump_ctrl (.mclk_in(mclk), .rst_in(rst), .demand_in(dem),
      .min_level_in(min_pin), .manual_run_button_in(manual_run_button), .stop_button_in(1'b0), .volt_meas_in(volt),
      .freq_meas_in(freq), .pump_run_out(run), .alarm_relay_out(rly), .volt_alarm_out(va), .freq_alarm_out(fa),
      .test_busy_out(busy), .s_axi_awaddr_in(awa), .s_axi_awvalid_in(awv), .s_axi_awready_out(awr),
      .s_axi_wdata_in(wd), .s_axi_wstrb_in(4'hf), .s_axi_wvalid_in(wv), .s_axi_wready_out(wrd),
      .s_axi_bresp_out(br), .s_axi_bvalid_out(bv), .s_axi_bready_in(bre), .s_axi_araddr_in(awa),
      .s_axi_arvalid_in(arv), .s_axi_arready_out(arr), .s_axi_rdata_out(rd), .s_axi_rresp_out(rr),
      .s_axi_rvalid_out(rv), .s_axi_rready_in(rre));
   pump_field u_pump_field (.mclk_in(mclk), .want_in(want), .demand_out(dem));
   ////////////////////////////////////////
   task chk(input logic [31:0] g, input logic [31:0] e);
      tests_run++;
      if (g !== e)
      begin
         n_fail++;
         $display("MISMATCH %0t got %h exp %h", $time, g, e);
      end
   endtask
   task results;
      if (n_fail == 0 && tests_run > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   task cyc(input int n);
      repeat (n) @(posedge mclk);
   endtask
   task bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      logic ok;
      ok = 1'b0;
      // Extra edge so a release from the last access is never overwritten
      @(posedge mclk);
      awa <= a;
      wd <= d;
      {awv, wv, bre} <= {3{w}};
      {arv, rre} <= {2{!w}};
      for (int i = 0; i < 50 && !ok; i++)
      begin
         @(posedge mclk);
         if (awr) awv <= 1'b0;
         if (wrd) wv <= 1'b0;
         if (arr) arv <= 1'b0;
         ok = w ? bv : rv;
         rsp = w ? br : rr;
         dat = rd;
      end
      {bre, rre} <= 2'h0;
      chk(32'(ok), 32'h1);
      chk(32'(rsp), 32'(er));
      if (!w) chk(dat, d);
      if (!ok) results;
   endtask
   initial
   begin
      cyc(3);
      rst <= 1'b0;
      bus(1'b0, 8'h00, 32'h02050104, 2'h0);
      bus(1'b0, 8'h04, 32'h016801b8, 2'h0);
      bus(1'b0, 8'h08, 32'h05020231, 2'h0);
      bus(1'b0, 8'h18, 32'h0, 2'h2);
      want <= 2'h1;
      cyc(25);
      chk(32'(run), 32'h0);
      cyc(25);
      chk(32'(run), 32'h1);
      want <= 2'h0;
      cyc(30);
      chk(32'(run), 32'h0);
      bus(1'b1, 8'h08, 32'h05020131, 2'h0);
      want <= 2'h3;
      cyc(60);
      bus(1'b0, 8'h10, 32'h1, 2'h0);
      volt <= 9'h1f4;
      cyc(30);
      volt <= 9'h190;
      cyc(20);
      chk(32'(va), 32'h0);
      volt <= 9'h1f4;
      cyc(65);
      chk(32'({rly, va, run}), 32'hc);
      volt <= 9'h12c;
      cyc(65);
      chk(32'(va), 32'h1);
      bus(1'b1, 8'h08, 32'h05020130, 2'h0);
      cyc(5);
      chk(32'(va), 32'h0);
      volt <= 9'h190;
      freq <= 7'h34;
      cyc(40);
      chk(32'(fa), 32'h0);
      freq <= 7'h35;
      cyc(40);
      chk(32'(fa), 32'h1);
      manual_run_button <= 2'h2;
      cyc(5);
      chk(32'(run), 32'h2);
      manual_run_button <= 2'h0;
      want <= 2'h0;
      freq <= 7'h32;
      min_pin <= 1'b1;
      cyc(5);
      chk(32'(run), 32'h0);
      bus(1'b1, 8'h0c, 32'h00050001, 2'h0);
      cyc(45);
      chk(32'({busy, run}), 32'h5);
      cyc(30);
      chk(32'({busy, run}), 32'h6);
      bus(1'b1, 8'h0c, 32'h00050000, 2'h0);
      cyc(40);
      chk(32'(busy), 32'h0);
      bus(1'b1, 8'h14, 32'h00000007, 2'h0);
      bus(1'b0, 8'h14, 32'h00000007, 2'h0);
      bus(1'b1, 8'h08, 32'h05020138, 2'h0);
      manual_run_button <= 2'h1;
      cyc(5);
      manual_run_button <= 2'h0;
      cyc(30);
      chk(32'(run), 32'h1);
      cyc(40);
      chk(32'(run), 32'h0);
      results;
   end
endmodule
`default_nettype wire
